/* File: hw/rx_cfg_pkg.sv */
/*
 constants, types and field layout of the receiver configuration word.
 assumes a single 20 MHz clock shared by both ends.
*/
package rx_cfg_pkg;
   localparam int WORD_BITS = 15;
   localparam int REG_BITS = 12;
   localparam int CYCLE_NS = 50;
   localparam int BIT_TIME_NS = 1000;
   localparam int BIT_CYCLES = (BIT_TIME_NS + CYCLE_NS - 1) / CYCLE_NS;
   localparam int MARKER_NS = 2000;
   localparam int MARKER_CYCLES = MARKER_NS / CYCLE_NS;
   localparam int SLEEP_UNIT_CLK = 1024;
   // word bit positions, word bit n is vector index n-1
   localparam int POS_OFF = 0;
   localparam int POS_ADDR = 1;
   localparam int POS_STOP = 14;
   // operating and limit register field positions within 12 bits, msb = word bit 3
   localparam int OP_BAUD_POS = 10;
   localparam int OP_CHECK_POS = 8;
   localparam int OP_MOD_POS = 7;
   localparam int OP_SLEEP_POS = 2;
   localparam int OP_STRETCH_POS = 1;
   localparam int OP_NOISE_POS = 0;
   localparam int LIM_MIN_POS = 6;
   localparam int LIM_MAX_POS = 0;
   localparam logic [11:0] OP_RESET = 12'h119;
   localparam logic [11:0] LIM_RESET = 12'h5_69;
   typedef logic [11:0] cfg_word_t;
endpackage : rx_cfg_pkg

/* File: hw/rx_cfg_if.sv */
/*
 single data line between host and receiver, open-drain, pulled high.
 assumes both ends on sys_clk.
*/
`timescale 1ns/100ps
`default_nettype none
interface rx_cfg_if;
   logic dev_oe;
   logic host_oe;
   logic line;
   assign line = ~(dev_oe | host_oe);
   modport device (output dev_oe, input line);
   modport host (output host_oe, input line);
endinterface : rx_cfg_if
`default_nettype wire

/* File: hw/rx_cfg_device.sv */
/*
 receiver end: shifts in 15-bit words from the data line, loads registers.
 assumes the line idles high, a low start bit leads each word, low = 0.
*/
`timescale 1ns/100ps
`default_nettype none
module rx_cfg_device
   import rx_cfg_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset_n,
   rx_cfg_if.device lnk,
   input wire logic voltage_drop,
   output logic [11:0] operating_settings,
   output logic [11:0] bit_check_window,
   output logic off_cmd,
   output logic [1:0] baud_range_sel,
   output logic [3:0] limit_scale_factor,
   output logic [1:0] check_count_sel,
   output logic [3:0] check_bits,
   output logic modulation_select,
   output logic [4:0] sleep_value,
   output logic [3:0] sleep_stretch,
   output logic noise_suppress,
   output logic [15:0] sleep_duration
);
   import rx_cfg_pkg::*;

   // receive sequencer states
   typedef enum logic [1:0] {
      IDLE,
      SHIFT,
      MARK,
      REST
   } st_t;

   // whole state of the receiver end
   typedef struct packed {
      // line and supply monitor synchronisers
      logic s1;
      logic s2;
      logic v1;
      logic v2;
      logic vd;
      // receive sequencer
      st_t st;
      logic [5:0] cnt;
      logic [3:0] nbit;
      logic [14:0] sh;
      // configuration registers
      cfg_word_t op;
      cfg_word_t lim;
      logic off;
      logic oe;
      // decoded fields, registered
      logic [3:0] scale;
      logic [3:0] chkn;
      logic [3:0] strf;
      logic [15:0] dur;
   } state_t;
   state_t q;
   state_t d;

   // baud code to limit scale factor
   function automatic logic [3:0] scale_of(input cfg_word_t w);
      return 4'h8 >> w[OP_BAUD_POS +: 2];
   endfunction : scale_of

   // check code to number of checked bits
   function automatic logic [3:0] checks_of(input cfg_word_t w);
      return 4'(3 * w[OP_CHECK_POS +: 2]);
   endfunction : checks_of

   // stretch bit to sleep extension factor
   function automatic logic [3:0] stretch_of(input cfg_word_t w);
      return w[OP_STRETCH_POS] ? 4'h8 : 4'h1;
   endfunction : stretch_of

   // sleep length in units of SLEEP_UNIT_CLK clocks
   function automatic logic [15:0] duration_of(input cfg_word_t w);
      return 16'(w[OP_SLEEP_POS +: 5]) * 16'(stretch_of(w));
   endfunction : duration_of

   // word bits 3 to 14 to register, word bit 3 in the msb
   function automatic cfg_word_t field_of(input logic [14:0] w);
      cfg_word_t r;
      r = {<<{w[POS_STOP - 1:POS_ADDR + 1]}};
      return r;
   endfunction : field_of

   always_comb begin
      d = q;
      // two-stage synchronisers for line and supply monitor
      d.s1 = lnk.line;
      d.s2 = q.s1;
      d.v1 = voltage_drop;
      d.v2 = q.v1;
      d.vd = q.v2;
      d.off = 1'b0;

      case (q.st)
         IDLE: begin
            d.oe = 1'b0;
            if (!q.s2) begin
               // start bit seen, first sample lands mid bit 1
               d.st = SHIFT;
               d.cnt = 6'(BIT_CYCLES + BIT_CYCLES / 2);
               d.nbit = 4'h0;
            end
         end
         SHIFT: begin
            if (q.cnt == 6'h0) begin
               d.cnt = 6'(BIT_CYCLES - 1);
               d.sh = {q.s2, q.sh[14:1]};
               d.nbit = q.nbit + 4'h1;
               if (q.nbit == 4'(WORD_BITS - 1)) begin
                  // stop bit still low, wait for idle before hunting
                  d.st = REST;
                  if (d.sh[POS_OFF]) begin
                     d.off = 1'b1;
                  end else if (!d.sh[POS_STOP]) begin
                     if (d.sh[POS_ADDR]) begin
                        d.op = field_of(d.sh);
                     end else begin
                        d.lim = field_of(d.sh);
                     end
                  end
               end
            end else begin
               d.cnt = q.cnt - 6'h1;
            end
         end
         MARK: begin
            if (q.cnt == 6'h0) begin
               d.oe = 1'b0;
               d.st = REST;
            end else begin
               d.oe = 1'b1;
               d.cnt = q.cnt - 6'h1;
            end
         end
         REST: begin
            if (q.s2) begin
               d.st = IDLE;
            end
         end
         default: begin
            d.st = IDLE;
         end
      endcase

      // supply monitor rise: contents lost, show the marker
      if (q.v2 && !q.vd) begin
         d.op = OP_RESET;
         d.lim = LIM_RESET;
         d.st = MARK;
         d.oe = 1'b1;
         d.cnt = 6'(MARKER_CYCLES - 1);
      end
      // decoded fields follow the next register value
      d.scale = scale_of(d.op);
      d.chkn = checks_of(d.op);
      d.strf = stretch_of(d.op);
      d.dur = duration_of(d.op);
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         q <= '{
            s1: 1'b1,
            s2: 1'b1,
            v1: 1'b0,
            v2: 1'b0,
            vd: 1'b0,
            st: IDLE,
            cnt: 6'h0,
            nbit: 4'h0,
            sh: 15'h0,
            op: OP_RESET,
            lim: LIM_RESET,
            off: 1'b0,
            oe: 1'b0,
            scale: scale_of(OP_RESET),
            chkn: checks_of(OP_RESET),
            strf: stretch_of(OP_RESET),
            dur: duration_of(OP_RESET)
         };
      end else begin
         q <= d;
      end
   end

   // outputs straight from the state register
   assign lnk.dev_oe = q.oe;
   assign operating_settings = q.op;
   assign bit_check_window = q.lim;
   assign off_cmd = q.off;
   assign baud_range_sel = q.op[OP_BAUD_POS +: 2];
   assign limit_scale_factor = q.scale;
   assign check_count_sel = q.op[OP_CHECK_POS +: 2];
   assign check_bits = q.chkn;
   assign modulation_select = q.op[OP_MOD_POS];
   assign sleep_value = q.op[OP_SLEEP_POS +: 5];
   assign sleep_stretch = q.strf;
   assign noise_suppress = q.op[OP_NOISE_POS];
   assign sleep_duration = q.dur;
endmodule : rx_cfg_device
`default_nettype wire

/* File: hw/rx_cfg_host.sv */
/*
 controller end: sends a start bit and 15-bit words, watches for marker.
 assumes software writes words on a plain port, read data one cycle later.
*/
`timescale 1ns/100ps
`default_nettype none
module rx_cfg_host
   import rx_cfg_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset_n,
   rx_cfg_if.host lnk,
   input wire logic [1:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [15:0] rdata
);
   import rx_cfg_pkg::*;
   typedef enum logic {IDLE, SEND} st_t;
   typedef struct packed {
      logic s1, s2;
      st_t st;
      logic [5:0] cnt, low;
      logic [3:0] nbit;
      logic [15:0] sh;
      logic oe, marker;
      logic [15:0] rd;
   } state_t;
   state_t q, d;
   always_comb begin
      d = q;
      d.s1 = lnk.line;
      d.s2 = q.s1;
      d.rd = 16'h0;
      if (rd) d.rd = {13'h0, q.marker, 1'b0, q.st == SEND};
      // clear first so that a marker in the same cycle wins
      if (rd && addr == 2'h1) d.marker = 1'b0;
      if (!q.s2 && !q.oe && q.st == IDLE) begin
         d.low = (q.low == 6'h3F) ? q.low : q.low + 6'h1;
         if (q.low == 6'(MARKER_CYCLES / 2)) d.marker = 1'b1;
      end else begin
         d.low = 6'h0;
      end
      case (q.st)
         IDLE: begin
            d.oe = 1'b0;
            if (wr && addr == 2'h0) begin
               d.st = SEND;
               d.sh = {1'b0, wdata[13:0], 1'b0};
               d.nbit = 4'h0;
               d.cnt = 6'(BIT_CYCLES - 1);
               // low start bit frames the word
               d.oe = 1'b1;
            end
         end
         SEND: begin
            if (q.cnt == 6'h0) begin
               d.cnt = 6'(BIT_CYCLES - 1);
               d.nbit = q.nbit + 4'h1;
               d.sh = {1'b0, q.sh[15:1]};
               d.oe = ~q.sh[1];
               if (q.nbit == 4'(WORD_BITS)) begin
                  d.st = IDLE;
                  d.oe = 1'b0;
               end
            end else begin
               d.cnt = q.cnt - 6'h1;
            end
         end
         default: d.st = IDLE;
      endcase
   end
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         q <= '{s1: 1'b1, s2: 1'b1, st: IDLE, cnt: 6'h0, low: 6'h0, nbit: 4'h0,
                sh: 16'h0, oe: 1'b0, marker: 1'b0, rd: 16'h0};
      end else begin
         q <= d;
      end
   end
   assign lnk.host_oe = q.oe;
   assign rdata = q.rd;
endmodule : rx_cfg_host
`default_nettype wire

/* File: tb/rx_cfg_monitor.sv */
/*
 checker on the data line between host and receiver ends.
 assumes one clock, async low reset, signals of rx_cfg_if as inputs.
*/
`timescale 1ns/100ps
`default_nettype none
module rx_cfg_monitor
   import rx_cfg_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic dev_oe,
   input wire logic host_oe,
   input wire logic line
);
   import rx_cfg_pkg::*;
   logic [8:0] hrun_q, hrun_d, drun_q, drun_d;
   always_comb begin
      hrun_d = host_oe ? hrun_q + 9'h001 : 9'h000;
      drun_d = dev_oe ? drun_q + 9'h001 : 9'h000;
   end
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         hrun_q <= 9'h000;
         drun_q <= 9'h000;
      end else begin
         hrun_q <= hrun_d;
         drun_q <= drun_d;
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   a_host_rst_idle: assert property ($rose(reset_n) |-> !host_oe)
      else $error("host drives after reset");
   a_dev_rst_idle: assert property ($rose(reset_n) |-> !dev_oe)
      else $error("device drives after reset");
   a_zero_bit_min: assert property ($rose(host_oe) |-> host_oe[*8])
      else $error("zero bit too short");
   a_bit_units: assert property ($fell(host_oe) |-> hrun_q % BIT_CYCLES == 0)
      else $error("low run not whole bits");
   a_word_span: assert property (hrun_q <= (WORD_BITS + 1) * BIT_CYCLES)
      else $error("low run longer than a word");
   a_marker_len: assert property ($fell(dev_oe) |-> drun_q == MARKER_CYCLES)
      else $error("marker length wrong");
   a_marker_max: assert property (drun_q <= MARKER_CYCLES)
      else $error("marker too long");
   a_marker_gap: assert property ($fell(dev_oe) |=> !dev_oe[*8])
      else $error("device drives again after marker");
   c_word: cover property ($fell(host_oe));
   c_marker: cover property ($fell(dev_oe));
   c_bit: cover property (hrun_q == 9'h014);
   c_line_low: cover property (!line && !host_oe);
endmodule : rx_cfg_monitor
`default_nettype wire

/* File: tb/testbench.sv */
/*
 bench for host and receiver ends joined on one data line.
 assumes the design package, interface and both ends.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; \
$display("mismatch %0t %h %h", $time, g, e); end end
module testbench;
   import rx_cfg_pkg::*;
   logic sys_clk, reset_n, vdrop, wr, rd, off_cmd, mod, noise;
   logic [1:0] addr, baud, chk;
   logic [15:0] wdata, rdata, dur, s;
   logic [11:0] op, lim;
   logic [3:0] scale, nbits, stretch;
   logic [4:0] sleep;
   int n_fail = 0, check_count = 0, offs = 0;
   rx_cfg_if i_rx_cfg_if();
   rx_cfg_device i_rx_cfg_device(.sys_clk(sys_clk), .reset_n(reset_n),
      .lnk(i_rx_cfg_if.device), .voltage_drop(vdrop), .operating_settings(op),
      .bit_check_window(lim), .off_cmd(off_cmd), .baud_range_sel(baud),
      .limit_scale_factor(scale), .check_count_sel(chk), .check_bits(nbits),
      .modulation_select(mod), .sleep_value(sleep), .sleep_stretch(stretch),
      .noise_suppress(noise), .sleep_duration(dur));
   rx_cfg_host i_rx_cfg_host(.sys_clk(sys_clk), .reset_n(reset_n),
      .lnk(i_rx_cfg_if.host), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata));
   rx_cfg_monitor mon(.sys_clk(sys_clk), .reset_n(reset_n), .dev_oe(i_rx_cfg_if.dev_oe),
      .host_oe(i_rx_cfg_if.host_oe), .line(i_rx_cfg_if.line));
   always @(posedge sys_clk) if (off_cmd === 1'b1) offs++;
   task conclude;
      $display("errors %0d checks %0d", n_fail, check_count);
      if (n_fail == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : conclude
   task rdreg(input logic [1:0] a);
      addr <= a;
      rd <= 1'b1;
      @(posedge sys_clk);
      rd <= 1'b0;
      @(posedge sys_clk);
      s = rdata;
   endtask : rdreg
   function automatic logic [13:0] wd(input logic b1, b2, input logic [11:0] v);
      logic [11:0] r;
      r = {<<{v}};
      return {r, b2, b1};
   endfunction : wd
   task send(input logic [13:0] w);
      int i;
      addr <= 2'h0; wdata <= {2'h0, w}; wr <= 1'b1; @(posedge sys_clk); wr <= 1'b0;
      repeat (2) @(posedge sys_clk);
      i = 0; s = 16'h0001;
      while (s[0] !== 1'b0 && i < 400) begin rdreg(2'h0); i++; end
      `CHK(i < 400, 1'b1)
      repeat (30) @(posedge sys_clk);
   endtask : send
   task t_dflt;
      `CHK({op, lim}, 24'h119_569)
      `CHK({scale, nbits, stretch}, 12'h831)
      `CHK({mod, noise, sleep, dur}, 23'h26_0006)
   endtask : t_dflt
   task t_op;
      logic [11:0] v;
      logic [4:0] sv;
      for (int i = 0; i < 4; i++) begin
         sv = 5'(31 - i * 10);
         v = {i[1:0], i[1:0], i[0], sv, i[1], ~i[0]};
         send(wd(1'b0, 1'b1, v));
         `CHK({op, lim}, {v, 12'h569})
         `CHK({baud, chk, mod, noise}, {i[1:0], i[1:0], i[0], ~i[0]})
         `CHK({scale, nbits}, {4'(8 >> i), 4'(3 * i)})
         `CHK({sleep, dur}, {sv, 16'(sv * (i[1] ? 8 : 1))})
         `CHK(stretch, (i[1] ? 4'h8 : 4'h1))
      end
   endtask : t_op
   task t_lim;
      send(wd(1'b0, 1'b0, {6'h0C, 6'h32}));
      `CHK({op, lim}, 24'hF86_332)
   endtask : t_lim
   task t_off;
      int n;
      n = offs;
      send(wd(1'b1, 1'b0, 12'h000));
      `CHK(offs, n + 1)
      `CHK({op, lim}, 24'hF86_332)
   endtask : t_off
   task t_mark;
      vdrop <= 1'b1; repeat (100) @(posedge sys_clk);
      rdreg(2'h0);
      `CHK(s[2], 1'b1)
      `CHK({op, lim}, 24'h119_569)
      rdreg(2'h1); rdreg(2'h0); vdrop <= 1'b0;
      `CHK(s[2], 1'b0)
      send(wd(1'b0, 1'b1, 12'hABC));
      `CHK(op, 12'hABC)
   endtask : t_mark
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   initial begin
      reset_n = 1'b0; vdrop = 1'b0; wr = 1'b0; rd = 1'b0; addr = 2'h0; wdata = 16'h0000;
      repeat (12) @(posedge sys_clk);
      reset_n <= 1'b1;
      @(posedge sys_clk);
      t_dflt(); t_op(); t_lim(); t_off(); t_mark();
      conclude();
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      n_fail++;
      conclude();
   end
endmodule : testbench
`default_nettype wire
